/* core/tkcs_defines.vh */
`ifndef TKCS_DEFINES_VH
`define TKCS_DEFINES_VH
`define TKCS_ADDR_FIRST 8'ha7
`define TKCS_ADDR_PAD_LO 8'hc1
`define TKCS_ADDR_PAD_MID 8'hc2
`define TKCS_ADDR_PAD_HI 8'hc3
`define TKCS_ADDR_SCAN_LO 8'hc5
`define TKCS_ADDR_SCAN_MID 8'hc6
`define TKCS_ADDR_SCAN_HI 8'hc7
`define TKCS_RST_FIRST 5'h1f
`define TKCS_RST_MASK 8'h00
`define TKCS_FIRST_MAX 5'h13
`define TKCS_CODE_REFCAP 5'h17
`define TKCS_CH_REFCAP 5'h17
`define TKCS_PAD_HI_BITS 5
`define TKCS_SCAN_HI_REF 7
`define TKCS_MODE_X1 2'h0
`define TKCS_MODE_X2 2'h1
`define TKCS_MODE_X4 2'h2
`define TKCS_MODE_X8 2'h3
`define TKCS_LIMIT_X1 5'h15
`define TKCS_LIMIT_X2 5'h10
`define TKCS_LIMIT_X4 5'h08
`define TKCS_LIMIT_X8 5'h04
`define TKCS_REP_X1 4'h0
`define TKCS_REP_X2 4'h1
`define TKCS_REP_X4 4'h3
`define TKCS_REP_X8 4'h7
`endif

/* core/tkcs_next_pick.v */
`timescale 1ns/1ps
`include "tkcs_defines.vh"
// picks the first enabled channel at or after start_ch (inclusive) or start_ch+1 (not inclusive), wrapping over 24 slots
module tkcs_next_pick (
    input wire [23:0] enable_mask,
    input wire [4:0] start_ch,
    input wire inclusive,
    output reg found,
    output reg [4:0] next_ch
);
    reg [5:0] k;
    reg [5:0] idx;
    reg [4:0] base;
    always @* begin
        found = 1'b0;
        next_ch = 5'h00;
        base = inclusive ? start_ch : start_ch + 5'h01;
        // farthest offset first, so the nearest candidate is the last one assigned
        for (k = 6'h00; k < 6'h18; k = k + 6'h01) begin
            idx = {1'b0, base} + (6'h17 - k);
            if (idx >= 6'h18)
                idx = idx - 6'h18;
            if (enable_mask[idx[4:0]]) begin
                found = 1'b1;
                next_ch = idx[4:0];
            end
        end
    end
endmodule

/* core/tkcs_top.v */
`timescale 1ns/1ps
`include "tkcs_defines.vh"
// Summary of operation
// - five-bit first channel, codes zero through nineteen
// - code 10111 starts at reference capacitor
// - low pad mask dedicates channels 0-7
// - middle pad mask dedicates channels 8-15
// - high pad bits 4-0 channels 20-16
// - low scan mask enables channels 0-7
// - middle scan mask enables channels 8-15
// - high scan bit 7 enables channel 23
// - high scan bits 4-0 channels 20-16
// - repeat mode: 1/2/4/8 scans, channel limit
// - auto restart repeats scans without restart
module tkcs_top (
    input wire SYS_CLK,
    input wire RST_N,
    input wire CLK_EN,
    input wire [7:0] SFR_ADDR,
    input wire SFR_WR,
    input wire SFR_RD,
    input wire [7:0] SFR_WDATA,
    output reg [7:0] SFR_RDATA,
    input wire [1:0] REPEAT_COUNT_MODE,
    input wire AUTO_RESTART,
    input wire CONVERSION_START,
    input wire CHANNEL_DONE,
    output reg [4:0] FIRST_CHANNEL,
    output reg [20:0] PAD_ASSIGN,
    output reg [23:0] SCAN_ENABLE,
    output reg SCAN_ACTIVE,
    output reg [4:0] SCAN_CHANNEL,
    output reg [3:0] SCAN_REPEAT,
    output reg SCAN_END
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_END = 3'b100;

    reg [4:0] first_q;
    reg [7:0] pad_lo_q, pad_mid_q, pad_hi_q;
    reg [7:0] scan_lo_q, scan_mid_q, scan_hi_q;
    reg [2:0] state_q, state_d;
    reg [4:0] ch_q, ch_d;
    reg [3:0] rep_q, rep_d;
    reg [4:0] cnt_q, cnt_d;
    reg [4:0] first_eff;
    reg [3:0] rep_max;
    reg [4:0] ch_limit;
    reg [7:0] rdata_d;
    reg start_pend_q;
    wire [23:0] en_mask;
    wire [20:0] pad_mask;
    wire pick_found;
    wire [4:0] pick_ch;
    wire first_found;
    wire [4:0] first_ch;
    genvar g;

    // bit-per-channel map; channels 21 and 22 do not exist
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_map
            assign en_mask[g] = scan_lo_q[g];
            assign en_mask[g + 8] = scan_mid_q[g];
            assign pad_mask[g] = pad_lo_q[g];
            assign pad_mask[g + 8] = pad_mid_q[g];
        end
        for (g = 0; g < `TKCS_PAD_HI_BITS; g = g + 1) begin : g_hi
            assign en_mask[g + 16] = scan_hi_q[g];
            assign pad_mask[g + 16] = pad_hi_q[g];
        end
    endgenerate
    assign en_mask[22:21] = 2'b00;
    assign en_mask[23] = scan_hi_q[`TKCS_SCAN_HI_REF];

    // an unlisted code falls back to channel 0 rather than a phantom slot
    always @* begin
        if (first_q == `TKCS_CODE_REFCAP)
            first_eff = `TKCS_CH_REFCAP;
        else if (first_q <= `TKCS_FIRST_MAX)
            first_eff = first_q;
        else
            first_eff = 5'h00;
    end

    always @* begin
        case (REPEAT_COUNT_MODE)
            `TKCS_MODE_X1: begin
                rep_max = `TKCS_REP_X1;
                ch_limit = `TKCS_LIMIT_X1;
            end
            `TKCS_MODE_X2: begin
                rep_max = `TKCS_REP_X2;
                ch_limit = `TKCS_LIMIT_X2;
            end
            `TKCS_MODE_X4: begin
                rep_max = `TKCS_REP_X4;
                ch_limit = `TKCS_LIMIT_X4;
            end
            default: begin
                rep_max = `TKCS_REP_X8;
                ch_limit = `TKCS_LIMIT_X8;
            end
        endcase
    end

    tkcs_next_pick u_first (
        .enable_mask(en_mask),
        .start_ch(first_eff),
        .inclusive(1'b1),
        .found(first_found),
        .next_ch(first_ch)
    );

    tkcs_next_pick u_next (
        .enable_mask(en_mask),
        .start_ch(ch_q),
        .inclusive(1'b0),
        .found(pick_found),
        .next_ch(pick_ch)
    );

    always @* begin
        state_d = state_q;
        ch_d = ch_q;
        rep_d = rep_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (start_pend_q && first_found) begin
                    state_d = ST_RUN;
                    ch_d = first_ch;
                    rep_d = 4'h0;
                    cnt_d = 5'h01;
                end
            end
            ST_RUN: begin
                if (CHANNEL_DONE) begin
                    if (rep_q != rep_max) begin
                        rep_d = rep_q + 4'h1;
                    end else if (cnt_q < ch_limit && pick_found && pick_ch != first_ch) begin
                        ch_d = pick_ch;
                        rep_d = 4'h0;
                        cnt_d = cnt_q + 5'h01;
                    end else begin
                        state_d = ST_END;
                    end
                end
            end
            ST_END: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @* begin
        case (SFR_ADDR)
            `TKCS_ADDR_FIRST: rdata_d = {3'b000, first_q};
            `TKCS_ADDR_PAD_LO: rdata_d = pad_lo_q;
            `TKCS_ADDR_PAD_MID: rdata_d = pad_mid_q;
            `TKCS_ADDR_PAD_HI: rdata_d = {3'b000, pad_hi_q[4:0]};
            `TKCS_ADDR_SCAN_LO: rdata_d = scan_lo_q;
            `TKCS_ADDR_SCAN_MID: rdata_d = scan_mid_q;
            `TKCS_ADDR_SCAN_HI: rdata_d = {scan_hi_q[7], 2'b00, scan_hi_q[4:0]};
            default: rdata_d = 8'h00;
        endcase
    end

    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            first_q <= `TKCS_RST_FIRST;
            pad_lo_q <= `TKCS_RST_MASK;
            pad_mid_q <= `TKCS_RST_MASK;
            pad_hi_q <= `TKCS_RST_MASK;
            scan_lo_q <= `TKCS_RST_MASK;
            scan_mid_q <= `TKCS_RST_MASK;
            scan_hi_q <= `TKCS_RST_MASK;
            state_q <= ST_IDLE;
            ch_q <= 5'h00;
            rep_q <= 4'h0;
            cnt_q <= 5'h00;
            start_pend_q <= 1'b0;
            SFR_RDATA <= 8'h00;
            FIRST_CHANNEL <= 5'h00;
            PAD_ASSIGN <= 21'h000000;
            SCAN_ENABLE <= 24'h000000;
            SCAN_ACTIVE <= 1'b0;
            SCAN_CHANNEL <= 5'h00;
            SCAN_REPEAT <= 4'h0;
            SCAN_END <= 1'b0;
        end else if (CLK_EN) begin
            if (SFR_WR) begin
                case (SFR_ADDR)
                    `TKCS_ADDR_FIRST: first_q <= SFR_WDATA[4:0];
                    `TKCS_ADDR_PAD_LO: pad_lo_q <= SFR_WDATA;
                    `TKCS_ADDR_PAD_MID: pad_mid_q <= SFR_WDATA;
                    `TKCS_ADDR_PAD_HI: pad_hi_q <= {3'b000, SFR_WDATA[4:0]};
                    `TKCS_ADDR_SCAN_LO: scan_lo_q <= SFR_WDATA;
                    `TKCS_ADDR_SCAN_MID: scan_mid_q <= SFR_WDATA;
                    `TKCS_ADDR_SCAN_HI: scan_hi_q <= {SFR_WDATA[7], 2'b00, SFR_WDATA[4:0]};
                    default: begin
                    end
                endcase
            end
            if (SFR_RD)
                SFR_RDATA <= rdata_d;
            // start is set over a finish that lands in the same cycle
            if (CONVERSION_START)
                start_pend_q <= 1'b1;
            else if (state_q == ST_END && !AUTO_RESTART)
                start_pend_q <= 1'b0;
            state_q <= state_d;
            ch_q <= ch_d;
            rep_q <= rep_d;
            cnt_q <= cnt_d;
            FIRST_CHANNEL <= first_eff;
            PAD_ASSIGN <= pad_mask;
            SCAN_ENABLE <= en_mask;
            SCAN_ACTIVE <= (state_d == ST_RUN);
            SCAN_CHANNEL <= ch_d;
            SCAN_REPEAT <= rep_d;
            SCAN_END <= (state_d == ST_END);
        end
    end
endmodule

/* tb/tkcs_properties.sv */
`timescale 1ns/1ps
module tkcs_properties (
    input logic SYS_CLK,
    input logic RST_N,
    input logic CLK_EN,
    input logic [7:0] SFR_ADDR,
    input logic SFR_WR,
    input logic SFR_RD,
    input logic [7:0] SFR_WDATA,
    input logic [7:0] SFR_RDATA,
    input logic [4:0] FIRST_CHANNEL,
    input logic [20:0] PAD_ASSIGN,
    input logic [23:0] SCAN_ENABLE,
    input logic SCAN_ACTIVE,
    input logic [4:0] SCAN_CHANNEL
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // a write lands in the register, then in the registered output one edge later
    wire wr_en = CLK_EN && SFR_WR;
    pad_low_write_a: assert property (wr_en && SFR_ADDR == 8'hc1 ##1 CLK_EN
        |-> ##1 PAD_ASSIGN[7:0] == $past(SFR_WDATA, 2)) else $error("pad low mask wrong");
    pad_mid_write_a: assert property (wr_en && SFR_ADDR == 8'hc2 ##1 CLK_EN
        |-> ##1 PAD_ASSIGN[15:8] == $past(SFR_WDATA, 2)) else $error("pad mid mask wrong");
    pad_high_write_a: assert property (wr_en && SFR_ADDR == 8'hc3 ##1 CLK_EN
        |-> ##1 PAD_ASSIGN[20:16] == $past(SFR_WDATA[4:0], 2)) else $error("pad high mask wrong");
    scan_low_write_a: assert property (wr_en && SFR_ADDR == 8'hc5 ##1 CLK_EN
        |-> ##1 SCAN_ENABLE[7:0] == $past(SFR_WDATA, 2)) else $error("scan low mask wrong");
    scan_mid_write_a: assert property (wr_en && SFR_ADDR == 8'hc6 ##1 CLK_EN
        |-> ##1 SCAN_ENABLE[15:8] == $past(SFR_WDATA, 2)) else $error("scan mid mask wrong");
    scan_high_write_a: assert property (wr_en && SFR_ADDR == 8'hc7 ##1 CLK_EN
        |-> ##1 SCAN_ENABLE[23:16] == {$past(SFR_WDATA[7], 2), 2'b00, $past(SFR_WDATA[4:0], 2)})
        else $error("scan high mask wrong");
    first_code_a: assert property (wr_en && SFR_ADDR == 8'ha7
        && (SFR_WDATA[4:0] <= 5'h13 || SFR_WDATA[4:0] == 5'h17) ##1 CLK_EN
        |-> ##1 FIRST_CHANNEL == $past(SFR_WDATA[4:0], 2)) else $error("first channel wrong");
    enabled_only_a: assert property (SCAN_ACTIVE |-> SCAN_ENABLE[SCAN_CHANNEL])
        else $error("scan on disabled channel");
    mask_read_a: assert property (CLK_EN && SFR_RD && SFR_ADDR == 8'hc2
        |=> SFR_RDATA == PAD_ASSIGN[15:8]) else $error("pad mid readback wrong");
endmodule
bind tkcs_top tkcs_properties i_props (.*);

/* tb/tb_touch_channel_select.sv */
`timescale 1ns/1ps
module tb_touch_channel_select;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, start = 0, done = 0, act, send, en = 1, auto_run = 0;
    logic [7:0] addr = 0, wdata = 0, rdata;
    logic [3:0] rep;
    logic [1:0] mode = 0;
    logic [4:0] first, ch;
    logic [20:0] pad;
    logic [23:0] sen;
    int fails = 0, compares = 0, ends = 0;
    tkcs_top i_dut (.SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(en), .SFR_ADDR(addr), .SFR_WR(wr),
        .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .REPEAT_COUNT_MODE(mode), .AUTO_RESTART(auto_run),
        .CONVERSION_START(start), .CHANNEL_DONE(done), .FIRST_CHANNEL(first), .PAD_ASSIGN(pad),
        .SCAN_ENABLE(sen), .SCAN_ACTIVE(act), .SCAN_CHANNEL(ch), .SCAN_REPEAT(rep), .SCAN_END(send));
    initial forever #4 clk = ~clk;
    // counting end pulses also catches one that stands longer than a cycle
    always @(posedge clk) if (send) ends <= ends + 1;
    task automatic end_of_test();
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic step(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic limit(int k);
        if (k > 40) begin
            fails++;
            end_of_test();
        end
    endtask
    task automatic wait_active();
        int k;
        k = 0;
        while (act !== 1'b1 && k <= 40) begin
            step();
            k++;
        end
        limit(k);
    endtask
    task automatic wait_end(int e0);
        int k;
        k = 0;
        while (ends == e0 && k <= 40) begin
            step();
            k++;
        end
        limit(k);
    endtask
    task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr8(logic [7:0] a, logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1;
        step();
        wr = 0;
        step();
    endtask
    task automatic rd8(logic [7:0] a, logic [7:0] exp);
        addr = a;
        rd = 1;
        step();
        rd = 0;
        step();
        chk("rdata", exp, rdata);
    endtask
    task automatic regs_test();
        chk("pad", 0, pad);
        chk("scan", 0, sen);
        chk("first", 0, first);
        rd8(8'ha7, 8'h1f);
        for (logic [7:0] a = 8'hc1; a < 8'hc8; a++) rd8(a, 8'h00);
        wr8(8'hc1, 8'ha5);
        wr8(8'hc2, 8'h3c);
        wr8(8'hc3, 8'hff);
        wr8(8'hc4, 8'h55);
        wr8(8'hc5, 8'h81);
        wr8(8'hc6, 8'h42);
        wr8(8'hc7, 8'hff);
        rd8(8'hc3, 8'h1f);
        rd8(8'hc4, 8'h00);
        rd8(8'hc7, 8'h9f);
        rd8(8'hc1, 8'ha5);
        rd8(8'hc2, 8'h3c);
        rd8(8'hc5, 8'h81);
        rd8(8'hc6, 8'h42);
        chk("pad", 21'h1f3ca5, pad);
        chk("scan", 24'h9f4281, sen);
    endtask
    task automatic first_test();
        for (int c = 0; c < 32; c++) begin
            wr8(8'ha7, 8'(c) | 8'he0);
            rd8(8'ha7, 8'(c));
            chk("first", (c < 20 || c == 23) ? c : 0, first);
        end
    endtask
    task automatic scan_test(logic [1:0] m, int n, logic [19:0] order);
        int e0;
        mode = m;
        e0 = ends;
        start = 1;
        step();
        start = 0;
        wait_active();
        for (int i = 0; i < n; i++) begin
            chk("channel", order[19 - 5 * i -: 5], ch);
            for (int r = 0; r < (1 << m); r++) begin
                chk("repeat", r, rep);
                done = 1;
                step();
                done = 0;
                step();
            end
        end
        wait_end(e0);
        step();
        chk("active", 0, act);
        chk("end pulses", 1, ends - e0);
    endtask
    task automatic auto_test();
        wr8(8'hc5, 8'h00);
        mode = 2'h0;
        auto_run = 1;
        start = 1;
        step();
        start = 0;
        // the second pass must come without a new start pulse
        for (int s = 0; s < 2; s++) begin
            wait_active();
            chk("channel", 5'h17, ch);
            auto_run = (s == 0);
            done = 1;
            step();
            done = 0;
            step();
        end
        step(3);
        chk("active", 0, act);
    endtask
    task automatic freeze_test();
        en = 0;
        wr8(8'hc6, 8'h5a);
        en = 1;
        rd8(8'hc6, 8'h00);
        chk("scan", 24'h800000, sen);
    endtask
    initial begin
        step(5);
        rst_n = 1;
        step();
        regs_test();
        first_test();
        wr8(8'hc5, 8'h24);
        wr8(8'hc6, 8'h00);
        wr8(8'hc7, 8'h80);
        wr8(8'ha7, 8'h05);
        for (int m = 0; m < 3; m++) scan_test(2'(m), 3, {5'd5, 5'd23, 5'd2, 5'd0});
        wr8(8'hc5, 8'h1f);
        wr8(8'ha7, 8'h17);
        scan_test(2'd3, 4, {5'd23, 5'd0, 5'd1, 5'd2});
        auto_test();
        freeze_test();
        end_of_test();
    end
endmodule
